// [rtl/awc_pkg.sv]
// shared constants and types for the extended write command handler
package awc_pkg;
  // command opcodes
  localparam logic [7:0] OPC_DMA_WR     = 8'h35;
  localparam logic [7:0] OPC_QUEUED_WR  = 8'h61;
  // task-file register addresses
  localparam logic [2:0] TF_DATA        = 3'h0;
  localparam logic [2:0] TF_ERRFEAT     = 3'h1;
  localparam logic [2:0] TF_SECCNT      = 3'h2;
  localparam logic [2:0] TF_SECNUM      = 3'h3;
  localparam logic [2:0] TF_CYLLO       = 3'h4;
  localparam logic [2:0] TF_CYLHI       = 3'h5;
  localparam logic [2:0] TF_DEVHEAD     = 3'h6;
  localparam logic [2:0] TF_CMDSTAT     = 3'h7;
  // status and error bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABT = 2;
  localparam int DH_FUA = 7;
  localparam logic [7:0] DH_LBA_MODE    = 8'h40;
  // sector geometry and counts
  localparam logic [7:0]  WORD_LAST     = 8'hff;
  localparam logic [16:0] SEC_MAX       = 17'h10000;
  localparam logic [16:0] SEC_ONE       = 17'h00001;
  localparam logic [3:0]  CMD_STEP_LAST = 4'hb;
  localparam logic [2:0]  RD_STEP_LAST  = 3'h7;
  // controller register offsets
  localparam logic [3:0] HR_LBA_LO      = 4'h0;
  localparam logic [3:0] HR_LBA_HI      = 4'h1;
  localparam logic [3:0] HR_COUNT       = 4'h2;
  localparam logic [3:0] HR_CTRL        = 4'h3;
  localparam logic [3:0] HR_GO          = 4'h4;
  localparam logic [3:0] HR_WORD        = 4'h5;
  localparam logic [3:0] HR_STATUS      = 4'h6;
  localparam logic [3:0] HR_MASK        = 4'h7;
  localparam logic [3:0] HR_ELBA_LO     = 4'h8;
  localparam logic [3:0] HR_ELBA_HI     = 4'h9;
  // controller status bits
  localparam int HS_DONE = 0;
  localparam int HS_ERR  = 1;
  localparam int HS_WORD = 2;
  localparam int HS_BUSY = 8;
  localparam int HS_FULL = 9;
  localparam logic [2:0] HS_RST         = 3'h0;
  localparam logic [2:0] HM_RST         = 3'h0;
  // device sequencer states
  typedef enum logic [2:0] {
    D_IDLE  = 3'b001,
    D_XFER  = 3'b010,
    D_FLUSH = 3'b100
  } awc_dev_state_e;
  // controller sequencer states
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_CMD  = 4'b0010,
    H_DATA = 4'b0100,
    H_STAT = 4'b1000
  } awc_host_state_e;
endpackage

// [rtl/awc_if.sv]
// task-file, dma and interrupt signals between controller and device
interface awc_if;
  logic        tf_wr;    // task-file write strobe
  logic        tf_rd;    // task-file read strobe
  logic        tf_hob;   // high-order-byte select on reads
  logic [2:0]  tf_addr;  // task-file register address
  logic [7:0]  tf_wdata; // write byte
  logic [7:0]  tf_rdata; // read byte, cycle after tf_rd
  logic        dmarq;    // device requests data words
  logic        dmack;    // one word moves this cycle
  logic [15:0] dma_data; // word from controller
  logic        intrq;    // device interrupt, level

  modport dev (
    input  tf_wr, tf_rd, tf_hob, tf_addr, tf_wdata, dmack, dma_data,
    output tf_rdata, dmarq, intrq
  );
  modport host (
    output tf_wr, tf_rd, tf_hob, tf_addr, tf_wdata, dmack, dma_data,
    input  tf_rdata, dmarq, intrq
  );
endinterface

// [rtl/awc_device.sv]
// device end: decodes and runs the two extended write commands
// Functional notes
// R1: opcode 35h selects extended dma write
// R2: opcode 61h selects queued write
// R3: dma write accepts sectors, then commits media
// R4: queued write accepts sectors, then commits media
// R5: payload moves as 16-bit words
// R6: host prepares its dma channel before command
// R7: words move only while dmarq is high
// R8: one interrupt per command after status valid
// R9: uncorrectable error stops at failing sector
// R10: queued write also ends at failing sector
// R11: count low byte from current register
// R12: count high byte from previous register
// R13: zero count means 65536 sectors
// R14: hob clear reads lba bytes 0 to 2
// R15: hob set reads lba bytes 3 to 5
// R16: lba from current then previous registers
// R17: queued length from feature register pair
// R18: host gives unique tag in count 7:3
// R19: fua queued write completes after media
//
// The register addresses and the plain strobed port were decided locally.
module awc_device
  import awc_pkg::*;
(
  input  wire logic        REF_CLK,      // 50 mhz clock
  input  wire logic        SYS_RST,      // synchronous reset
  awc_if.dev               TF,           // link to controller
  input  wire logic        CACHE_EN,     // write cache enabled
  input  wire logic        MEDIA_FAULT,  // sector failed to write
  input  wire logic        MEDIA_DONE,   // media commit finished
  output logic             MEDIA_WVALID, // word valid to media
  output logic [15:0]      MEDIA_WDATA,  // word to media
  output logic [47:0]      MEDIA_LBA,    // sector of that word
  output logic             MEDIA_FLUSH   // waiting on media commit
);
  awc_dev_state_e state_q;      // sequencer
  logic [7:0]  cur_q [1:5];     // current task-file bytes
  logic [7:0]  prv_q [1:5];     // previous task-file bytes
  logic [7:0]  dh_q;            // device/head byte
  logic [47:0] lba_q;           // sector being moved
  logic [16:0] sec_left_q;      // sectors still to move
  logic [7:0]  word_q;          // word index in sector
  logic        queued_q;        // queued command running
  logic        fua_q;           // forced media write
  logic        err_q;           // status error bit
  logic [7:0]  err_reg_q;       // error register
  logic        intrq_q;         // pending interrupt
  logic [7:0]  rdata_q;         // read answer
  logic        mwv_q;           // media word strobe
  logic [15:0] mwd_q;           // media word
  logic [47:0] mlba_q;          // media word sector
  logic        cmd_wr;          // command byte written
  logic        word_take;       // word moves now
  logic        sec_end;         // last word of a sector
  logic        finish;          // command completes now
  logic        fail;            // command fails now
  logic [15:0] cnt_sel;         // raw sector count
  logic [7:0]  status;          // status byte

  // pick one byte of the reported lba
  function automatic logic [7:0] lba_byte(input logic [47:0] lba,
                                          input logic [2:0] idx);
    lba_byte = lba[idx*8 +: 8];
  endfunction

  // writes are taken only while idle, like a busy drive
  assign cmd_wr = TF.tf_wr && TF.tf_addr == TF_CMDSTAT
                  && state_q == D_IDLE;
  // a word moves only in the data phase while dmarq is up
  assign word_take = TF.dmack && state_q == D_XFER; // [R5] [R7]
  assign sec_end = word_take && word_q == WORD_LAST;

  // count source differs by command
  always_comb begin
    if (TF.tf_wdata == OPC_QUEUED_WR) begin
      cnt_sel = {prv_q[TF_ERRFEAT], cur_q[TF_ERRFEAT]}; // [R17]
    end else begin
      cnt_sel = {prv_q[TF_SECCNT], cur_q[TF_SECCNT]}; // [R11] [R12]
    end
  end

  // completion: cached queued writes without fua need no media wait
  always_comb begin
    finish = 1'b0;
    if (state_q == D_FLUSH) begin
      if (queued_q && !fua_q && CACHE_EN) begin
        finish = 1'b1;
      end else begin
        finish = MEDIA_DONE; // [R3] [R4] [R19]
      end
    end
  end
  // a fault on the last word of a sector fails that sector
  assign fail = sec_end && MEDIA_FAULT; // [R9] [R10]

  // task-file byte registers: a write pushes current into previous
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      for (int i = 1; i <= 5; i++) begin
        cur_q[i] <= 8'h00;
        prv_q[i] <= 8'h00;
      end
      dh_q <= DH_LBA_MODE;
    end else if (TF.tf_wr && state_q == D_IDLE) begin
      if (TF.tf_addr >= TF_ERRFEAT && TF.tf_addr <= TF_CYLHI) begin
        prv_q[TF.tf_addr] <= cur_q[TF.tf_addr];
        cur_q[TF.tf_addr] <= TF.tf_wdata;
      end
      if (TF.tf_addr == TF_DEVHEAD) begin
        dh_q <= TF.tf_wdata;
      end
    end
  end

  // command sequencer
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_q <= D_IDLE;
    end else begin
      unique case (state_q)
        D_IDLE: begin
          // only the two write opcodes start a transfer
          if (cmd_wr && (TF.tf_wdata == OPC_DMA_WR // [R1]
                         || TF.tf_wdata == OPC_QUEUED_WR)) begin // [R2]
            state_q <= D_XFER;
          end
        end
        D_XFER: begin
          if (fail) begin
            state_q <= D_IDLE; // [R9] [R10]
          end else if (sec_end && sec_left_q == SEC_ONE) begin
            state_q <= D_FLUSH;
          end
        end
        D_FLUSH: begin
          if (finish) begin
            state_q <= D_IDLE;
          end
        end
      endcase
    end
  end

  // address, count and mode capture, then sector stepping
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      lba_q      <= 48'h0;
      sec_left_q <= 17'h0;
      queued_q   <= 1'b0;
      fua_q      <= 1'b0;
    end else if (cmd_wr) begin
      lba_q <= {prv_q[TF_CYLHI], prv_q[TF_CYLLO], prv_q[TF_SECNUM],
                cur_q[TF_CYLHI], cur_q[TF_CYLLO],
                cur_q[TF_SECNUM]}; // [R16]
      // zero asks for the largest transfer
      sec_left_q <= (cnt_sel == 16'h0) ? SEC_MAX
                                       : {1'b0, cnt_sel}; // [R13]
      queued_q <= TF.tf_wdata == OPC_QUEUED_WR;
      fua_q    <= dh_q[DH_FUA]; // [R19]
    end else if (sec_end && !fail) begin
      // failing sector stays in lba_q for reporting
      lba_q      <= lba_q + 48'h1;
      sec_left_q <= sec_left_q - SEC_ONE;
    end
  end

  // word index inside the sector
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || cmd_wr) begin
      word_q <= 8'h00;
    end else if (word_take) begin
      word_q <= word_q + 8'h01;
    end
  end

  // error state: abort on unknown opcode or media fault
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      err_q     <= 1'b0;
      err_reg_q <= 8'h00;
    end else if (cmd_wr) begin
      err_q     <= TF.tf_wdata != OPC_DMA_WR
                   && TF.tf_wdata != OPC_QUEUED_WR;
      err_reg_q <= 8'h00;
      err_reg_q[ER_ABT] <= TF.tf_wdata != OPC_DMA_WR
                           && TF.tf_wdata != OPC_QUEUED_WR;
    end else if (fail) begin
      err_q             <= 1'b1; // [R9] [R10]
      err_reg_q[ER_ABT] <= 1'b1;
    end
  end

  // interrupt: raised once at the end, dropped by a status read
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      intrq_q <= 1'b0;
    end else if (finish || fail || (cmd_wr && TF.tf_wdata != OPC_DMA_WR
                 && TF.tf_wdata != OPC_QUEUED_WR)) begin
      intrq_q <= 1'b1; // [R8] set wins over the read below
    end else if (TF.tf_rd && TF.tf_addr == TF_CMDSTAT) begin
      intrq_q <= 1'b0;
    end
  end

  // status byte from live state
  always_comb begin
    status         = 8'h00;
    status[ST_BSY] = state_q != D_IDLE;
    status[ST_RDY] = 1'b1;
    status[ST_DSC] = 1'b1;
    status[ST_DRQ] = state_q == D_XFER;
    status[ST_ERR] = err_q;
  end

  // read port, answer stands in the cycle after the strobe
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rdata_q <= 8'h00;
    end else if (TF.tf_rd) begin
      unique case (TF.tf_addr)
        TF_ERRFEAT: rdata_q <= err_reg_q;
        TF_SECNUM:  rdata_q <= lba_byte(lba_q, TF.tf_hob ? 3'd3
                                                         : 3'd0); // [R14]
        TF_CYLLO:   rdata_q <= lba_byte(lba_q, TF.tf_hob ? 3'd4
                                                         : 3'd1); // [R15]
        TF_CYLHI:   rdata_q <= lba_byte(lba_q, TF.tf_hob ? 3'd5
                                                         : 3'd2); // [R14] [R15]
        TF_DEVHEAD: rdata_q <= dh_q;
        TF_CMDSTAT: rdata_q <= status;
        default:    rdata_q <= 8'h00;
      endcase
    end
  end

  // media word path, one registered word per accepted transfer
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      mwv_q  <= 1'b0;
      mwd_q  <= 16'h0;
      mlba_q <= 48'h0;
    end else begin
      mwv_q <= word_take; // [R3] [R4]
      if (word_take) begin
        mwd_q  <= TF.dma_data;
        mlba_q <= lba_q;
      end
    end
  end

  assign TF.tf_rdata  = rdata_q;
  assign TF.dmarq     = state_q == D_XFER; // [R7]
  assign TF.intrq     = intrq_q;
  assign MEDIA_WVALID = mwv_q;
  assign MEDIA_WDATA  = mwd_q;
  assign MEDIA_LBA    = mlba_q;
  assign MEDIA_FLUSH  = state_q == D_FLUSH;
endmodule

// [rtl/awc_host.sv]
// controller end: issues the write commands from software registers
module awc_host
  import awc_pkg::*;
(
  input  wire logic        REF_CLK, // 50 mhz clock
  input  wire logic        SYS_RST, // synchronous reset
  awc_if.host              TF,      // link to device
  input  wire logic [3:0]  ADDR,    // register offset
  input  wire logic [31:0] WDATA,   // write data
  input  wire logic        WR,      // write strobe
  input  wire logic        RD,      // read strobe
  output logic      [31:0] RDATA,   // read data, cycle after RD
  output logic             IRQ      // level interrupt
);
  awc_host_state_e state_q;   // sequencer
  logic [47:0] lba_q;         // start lba
  logic [15:0] count_q;       // sector count
  logic [6:0]  ctrl_q;        // queued, fua, tag
  logic [15:0] word_q;        // one-word holding register
  logic        full_q;        // holding register loaded
  logic [2:0]  sts_q;         // sticky events
  logic [2:0]  mask_q;        // event mask
  logic [47:0] elba_q;        // reported lba
  logic [7:0]  ecode_q;       // device error byte
  logic [3:0]  step_q;        // command write step
  logic [2:0]  rstep_q;       // readback step
  logic        ph_q;          // readback phase: 0 strobe, 1 capture
  logic [31:0] rdata_q;       // register read answer
  logic [10:0] wbyte;         // {addr, byte} of this write step
  logic [3:0]  rsel;          // {hob, addr} of this read step
  logic [2:0]  ev;            // events this cycle

  // byte sequence of the command: previous before current
  function automatic logic [10:0] cmd_step(input logic [3:0] s,
      input logic [47:0] l, input logic [15:0] c, input logic [6:0] k);
    logic [15:0] feat;
    logic [15:0] cnt;
    feat = k[0] ? c : 16'h0;                              // [R17]
    cnt  = k[0] ? {8'h00, k[6:2], 3'h0} : c;              // [R18]
    unique case (s)
      4'h0: cmd_step = {TF_ERRFEAT, feat[15:8]};
      4'h1: cmd_step = {TF_ERRFEAT, feat[7:0]};
      4'h2: cmd_step = {TF_SECCNT, cnt[15:8]};            // [R12]
      4'h3: cmd_step = {TF_SECCNT, cnt[7:0]};             // [R11]
      4'h4: cmd_step = {TF_SECNUM, l[31:24]};             // [R16]
      4'h5: cmd_step = {TF_SECNUM, l[7:0]};
      4'h6: cmd_step = {TF_CYLLO, l[39:32]};
      4'h7: cmd_step = {TF_CYLLO, l[15:8]};
      4'h8: cmd_step = {TF_CYLHI, l[47:40]};
      4'h9: cmd_step = {TF_CYLHI, l[23:16]};
      4'ha: cmd_step = {TF_DEVHEAD, DH_LBA_MODE | {k[1] & k[0], 7'h0}};
      default: cmd_step = {TF_CMDSTAT, k[0] ? OPC_QUEUED_WR // [R2]
                                            : OPC_DMA_WR}; // [R1]
    endcase
  endfunction

  // readback order: status, error, lba bytes hob clear then set
  function automatic logic [3:0] rd_step(input logic [2:0] s);
    unique case (s)
      3'h0: rd_step = {1'b0, TF_CMDSTAT};
      3'h1: rd_step = {1'b0, TF_ERRFEAT};
      3'h2: rd_step = {1'b0, TF_SECNUM};
      3'h3: rd_step = {1'b0, TF_CYLLO};
      3'h4: rd_step = {1'b0, TF_CYLHI};
      3'h5: rd_step = {1'b1, TF_SECNUM};
      3'h6: rd_step = {1'b1, TF_CYLLO};
      default: rd_step = {1'b1, TF_CYLHI};
    endcase
  endfunction

  assign wbyte = cmd_step(step_q, lba_q, count_q, ctrl_q);
  assign rsel  = rd_step(rstep_q);

  // sequencer: setup is done before the command byte goes out
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_q <= H_IDLE;
      step_q  <= 4'h0;
      rstep_q <= 3'h0;
      ph_q    <= 1'b0;
    end else begin
      unique case (state_q)
        H_IDLE: begin
          if (WR && ADDR == HR_GO) begin
            state_q <= H_CMD; // [R6]
            step_q  <= 4'h0;
          end
        end
        H_CMD: begin
          step_q <= step_q + 4'h1;
          if (step_q == CMD_STEP_LAST) begin
            state_q <= H_DATA;
          end
        end
        H_DATA: begin
          // words keep flowing until the device interrupts
          if (TF.intrq) begin
            state_q <= H_STAT;
            rstep_q <= 3'h0;
            ph_q    <= 1'b0;
          end
        end
        H_STAT: begin
          ph_q <= !ph_q;
          if (ph_q) begin
            rstep_q <= rstep_q + 3'h1;
            // stop after status unless it reports an error
            if ((rstep_q == 3'h0 && !TF.tf_rdata[ST_ERR])
                || rstep_q == RD_STEP_LAST) begin
              state_q <= H_IDLE;
            end
          end
        end
      endcase
    end
  end

  // capture of error byte and failing lba
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      elba_q  <= 48'h0;
      ecode_q <= 8'h00;
    end else if (state_q == H_STAT && ph_q) begin
      unique case (rstep_q)
        3'h0: ecode_q <= 8'h00;
        3'h1: ecode_q <= TF.tf_rdata;
        3'h2: elba_q[7:0]   <= TF.tf_rdata; // [R14]
        3'h3: elba_q[15:8]  <= TF.tf_rdata;
        3'h4: elba_q[23:16] <= TF.tf_rdata;
        3'h5: elba_q[31:24] <= TF.tf_rdata; // [R15]
        3'h6: elba_q[39:32] <= TF.tf_rdata;
        default: elba_q[47:40] <= TF.tf_rdata;
      endcase
    end
  end

  // event pulses: done, error, word consumed
  always_comb begin
    ev          = 3'h0;
    ev[HS_DONE] = state_q == H_STAT && ph_q
                  && (rstep_q == RD_STEP_LAST
                      || (rstep_q == 3'h0 && !TF.tf_rdata[ST_ERR]));
    ev[HS_ERR]  = state_q == H_STAT && ph_q && rstep_q == 3'h0
                  && TF.tf_rdata[ST_ERR];
    ev[HS_WORD] = TF.dmack;
  end

  // software registers; sticky bits clear on writing one, set wins
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      lba_q   <= 48'h0;
      count_q <= 16'h0;
      ctrl_q  <= 7'h0;
      mask_q  <= HM_RST;
      sts_q   <= HS_RST;
    end else begin
      if (WR && ADDR == HR_LBA_LO) lba_q[31:0]  <= WDATA;
      if (WR && ADDR == HR_LBA_HI) lba_q[47:32] <= WDATA[15:0];
      if (WR && ADDR == HR_COUNT)  count_q      <= WDATA[15:0];
      if (WR && ADDR == HR_CTRL)   ctrl_q       <= WDATA[6:0];
      if (WR && ADDR == HR_MASK)   mask_q       <= WDATA[2:0];
      sts_q <= (sts_q & ~((WR && ADDR == HR_STATUS) ? WDATA[2:0]
                                                    : 3'h0)) | ev;
    end
  end

  // one-word holder; software refills after each word event
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      word_q <= 16'h0;
      full_q <= 1'b0;
    end else if (TF.dmack) begin
      full_q <= 1'b0;
    end else if (WR && ADDR == HR_WORD && !full_q) begin
      word_q <= WDATA[15:0];
      full_q <= 1'b1;
    end
  end

  // register read answer
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rdata_q <= 32'h0;
    end else if (RD) begin
      unique case (ADDR)
        HR_LBA_LO:  rdata_q <= lba_q[31:0];
        HR_LBA_HI:  rdata_q <= {16'h0, lba_q[47:32]};
        HR_COUNT:   rdata_q <= {16'h0, count_q};
        HR_CTRL:    rdata_q <= {25'h0, ctrl_q};
        HR_STATUS:  rdata_q <= {22'h0, full_q, state_q != H_IDLE,
                                5'h0, sts_q};
        HR_MASK:    rdata_q <= {29'h0, mask_q};
        HR_ELBA_LO: rdata_q <= elba_q[31:0];
        HR_ELBA_HI: rdata_q <= {8'h0, ecode_q, elba_q[47:32]};
        default:    rdata_q <= 32'h0;
      endcase
    end
  end

  assign TF.tf_wr    = state_q == H_CMD;
  assign TF.tf_addr  = state_q == H_STAT ? rsel[2:0] : wbyte[10:8];
  assign TF.tf_wdata = wbyte[7:0];
  assign TF.tf_rd    = state_q == H_STAT && !ph_q;
  assign TF.tf_hob   = state_q == H_STAT && rsel[3];
  assign TF.dmack    = TF.dmarq && full_q && state_q == H_DATA; // [R7]
  assign TF.dma_data = word_q; // [R5]
  assign RDATA       = rdata_q;
  assign IRQ         = |(sts_q & mask_q);
endmodule

// [dv/awc_asserts.sv]
// link checks between controller and device ends
module awc_asserts
  import awc_pkg::*;
(
  input wire logic       REF_CLK,  // 50 mhz clock
  input wire logic       SYS_RST,  // sync reset
  input wire logic       tf_wr,    // task-file write
  input wire logic       tf_rd,    // task-file read
  input wire logic [2:0] tf_addr,  // register address
  input wire logic [7:0] tf_wdata, // write byte
  input wire logic [7:0] tf_rdata, // read byte
  input wire logic       dmarq,    // word request
  input wire logic       dmack,    // word moves
  input wire logic       intrq     // device interrupt
);
  logic [7:0] wcnt_q; // words in sector, wraps at 256
  // wrap to zero marks a sector edge, so partial sectors show up
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || !dmarq) wcnt_q <= 8'h00;
    else if (dmack) wcnt_q <= wcnt_q + 8'h01;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // command byte of either write opcode
  sequence cmd_s;
    tf_wr && tf_addr == TF_CMDSTAT &&
      (tf_wdata == OPC_DMA_WR || tf_wdata == OPC_QUEUED_WR);
  endsequence
  // status read while the interrupt stands
  sequence stat_rd_s;
    tf_rd && tf_addr == TF_CMDSTAT && intrq;
  endsequence
  cmd_start_a: assert property (cmd_s |=> dmarq)
    else $error("data phase did not follow command");
  rq_cause_a: assert property ($rose(dmarq) |-> $past(tf_wr))
    else $error("word request without command write");
  word_qual_a: assert property (dmack |-> dmarq)
    else $error("word moved without request");
  sector_whole_a: assert property ($fell(dmarq) |-> wcnt_q == 8'h00)
    else $error("data phase ended inside a sector");
  no_wr_xfer_a: assert property (dmarq |-> !tf_wr)
    else $error("task-file write during data phase");
  intr_late_a: assert property (dmarq |-> !intrq)
    else $error("interrupt before transfer ended");
  intr_hold_a: assert property ($fell(intrq) |-> $past(tf_rd) &&
    $past(tf_addr) == TF_CMDSTAT) else $error("interrupt dropped early");
  stat_valid_a: assert property (stat_rd_s |=>
    !tf_rdata[ST_BSY] && tf_rdata[ST_RDY]) else $error("status not valid");
  intr_due_a: assert property ($fell(dmarq) |-> ##[1:64] intrq)
    else $error("no interrupt after transfer");
endmodule

// [dv/tb_top.sv]
// bench: controller and device joined over the link
module tb_top
  import awc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK = 1'b0;  // 50 mhz
  logic        SYS_RST = 1'b1;  // sync reset
  logic [3:0]  addr = 4'h0;     // register offset
  logic [31:0] wdata = 32'h0;   // write data
  logic        wr = 1'b0;       // write strobe
  logic        rd = 1'b0;       // read strobe
  logic [31:0] rdata;           // read data
  logic        irq;             // controller interrupt
  logic        cache_en = 1'b0; // write cache
  logic        fault = 1'b0;    // media failure
  logic        mdone = 1'b0;    // media commit done
  logic        m_wv;            // word to media
  logic        m_fl;            // flush pending
  logic [15:0] m_wd;            // media word
  logic [47:0] m_lba;           // media sector
  logic [47:0] last_lba;        // sector of last word
  int          n_fail = 0;      // mismatches
  int          samples_checked = 0;
  int          nw = 0;          // words seen at media
  int          nfl = 0;         // flush cycles seen
  int          cyc = 0;         // cycle count
  awc_if u_awc_if ();
  awc_device u_awc_device (.REF_CLK, .SYS_RST, .TF(u_awc_if.dev),
    .CACHE_EN(cache_en), .MEDIA_FAULT(fault), .MEDIA_DONE(mdone),
    .MEDIA_WVALID(m_wv), .MEDIA_WDATA(m_wd), .MEDIA_LBA(m_lba),
    .MEDIA_FLUSH(m_fl));
  awc_host u_awc_host (.REF_CLK, .SYS_RST, .TF(u_awc_if.host), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq));
  awc_asserts u_awc_asserts (.REF_CLK, .SYS_RST, .tf_wr(u_awc_if.tf_wr),
    .tf_rd(u_awc_if.tf_rd), .tf_addr(u_awc_if.tf_addr),
    .tf_wdata(u_awc_if.tf_wdata), .tf_rdata(u_awc_if.tf_rdata),
    .dmarq(u_awc_if.dmarq), .dmack(u_awc_if.dmack), .intrq(u_awc_if.intrq));
  always #10 REF_CLK = ~REF_CLK;
  // media commits one cycle after asked
  always @(posedge REF_CLK) mdone <= m_fl;
  // words must reach media in order; sampled mid-cycle to avoid races
  always @(negedge REF_CLK) begin
    if (m_wv === 1'b1) begin
      chk("media word", {32'h0, 16'(nw) ^ 16'h5a00}, {32'h0, m_wd});
      last_lba = m_lba;
      nw++;
    end
    if (m_fl === 1'b1) nfl++;
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      end_sim();
    end
  end
  // compare and count
  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle register write
  task automatic reg_wr(logic [3:0] a, logic [31:0] d);
    @(posedge REF_CLK);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge REF_CLK);
    wr <= 1'b0;
  endtask
  // read; data stands from the following cycle on
  task automatic reg_rd(logic [3:0] a, output logic [31:0] d);
    @(posedge REF_CLK);
    addr <= a;
    rd <= 1'b1;
    @(posedge REF_CLK);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded wait on a status bit
  task automatic poll(int idx);
    logic [31:0] d;
    for (int k = 0; k < 400; k++) begin
      reg_rd(HR_STATUS, d);
      if (d[idx] === 1'b1) break;
    end
    chk("status bit", 48'h1, {47'h0, d[idx]});
  endtask
  // one word at a time; the controller holds a single word
  task automatic send(int n);
    for (int i = 0; i < n; i++) begin
      reg_wr(HR_WORD, 32'(16'(i) ^ 16'h5a00));
      poll(HS_WORD);
      reg_wr(HR_STATUS, 32'h4);
    end
  endtask
  task automatic start(logic [47:0] l, logic [15:0] c, logic [6:0] k);
    nw = 0;
    nfl = 0;
    reg_wr(HR_LBA_LO, l[31:0]);
    reg_wr(HR_LBA_HI, {16'h0, l[47:32]});
    reg_wr(HR_COUNT, {16'h0, c});
    reg_wr(HR_CTRL, {25'h0, k});
    reg_wr(HR_GO, 32'h1);
  endtask
  // reset values and an unmapped offset
  task automatic t_regs();
    logic [31:0] d;
    reg_rd(HR_STATUS, d);
    chk("status rst", 48'h0, {16'h0, d});
    reg_rd(HR_MASK, d);
    chk("mask rst", 48'h0, {16'h0, d});
    reg_rd(4'hf, d);
    chk("unmapped", 48'h0, {16'h0, d});
  endtask
  // one-sector 35h write, done masked, then unmask and clear
  task automatic t_dma();
    start(48'h123456789abc, 16'h0001, 7'h00);
    send(256);
    poll(HS_DONE);
    chk("irq masked", 48'h0, {47'h0, irq});
    chk("words", 48'd256, 48'(nw));
    chk("lba", 48'h123456789abc, last_lba);
    reg_wr(HR_MASK, 32'h1);
    #1 chk("irq on", 48'h1, {47'h0, irq});
    reg_wr(HR_STATUS, 32'h1);
    #1 chk("irq off", 48'h0, {47'h0, irq});
  endtask
  // queued 2-sector write failing in sector one
  task automatic t_fault();
    logic [31:0] d;
    cache_en <= 1'b1;
    fault <= 1'b1;
    reg_wr(HR_MASK, 32'h2);
    start(48'h0a0b0c0d0e0f, 16'h0002, 7'h0d);
    send(256);
    poll(HS_ERR);
    chk("irq err", 48'h1, {47'h0, irq});
    fault <= 1'b0;
    chk("words", 48'd256, 48'(nw));
    // lba bytes are still arriving when the error bit sets
    poll(HS_DONE);
    reg_rd(HR_ELBA_LO, d);
    chk("elba lo", 48'h0c0d0e0f, {16'h0, d});
    reg_rd(HR_ELBA_HI, d);
    chk("elba hi", 48'h040a0b, {16'h0, d});
    reg_wr(HR_STATUS, 32'h3);
    #1 chk("irq clr", 48'h0, {47'h0, irq});
  endtask
  // cached queued write with fua still waits on the media commit
  task automatic t_fua();
    start(48'h000000000100, 16'h0001, 7'h07);
    send(256);
    poll(HS_DONE);
    chk("words", 48'd256, 48'(nw));
    chk("fua flush", 48'd2, 48'(nfl));
  endtask
  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    t_regs();
    t_dma();
    t_fault();
    t_fua();
    end_sim();
  end
endmodule
